// >>> rtl/pfp_map.svh
// constants of the pulse fuse programming logic
`ifndef PFP_MAP_SVH
`define PFP_MAP_SVH

`define PFP_CLK_PERIOD_NS  25
`define PFP_T_BLOW_NS      30000
`define PFP_BLOW_CYCLES    ((`PFP_T_BLOW_NS + `PFP_CLK_PERIOD_NS - 1) / `PFP_CLK_PERIOD_NS)

`define PFP_CODE_W         6
`define PFP_CODE_ZERO      6'h00
`define PFP_GAIN_MAX       6'h3f
`define PFP_QLEV_MAX       6'h3f
`define PFP_K3_MAX         6'h1f

`define PFP_KEY_NONE       2'h0
`define PFP_KEY_GAIN       2'h1
`define PFP_KEY_QLEV       2'h2
`define PFP_KEY_K3         2'h3

`define PFP_TC_LSB         0
`define PFP_TC_MSB         2
`define PFP_SLOPE_BIT      3
`define PFP_LOCK_BIT       4

`define PFP_FS_GAIN_LSB    0
`define PFP_FS_GAIN_MSB    5
`define PFP_FS_QLEV_LSB    6
`define PFP_FS_QLEV_MSB    11
`define PFP_FS_K3_LSB      12
`define PFP_FS_K3_MSB      17

`endif

// >>> rtl/pfp_pkg.sv
// types of the pulse fuse programming logic
package pfp_pkg;

  typedef enum logic [4:0] {
    PFP_ST_INIT  = 5'h01,
    PFP_ST_SEL   = 5'h02,
    PFP_ST_ADDR  = 5'h04,
    PFP_ST_BLOW  = 5'h08,
    PFP_ST_DONE  = 5'h10
  } pfp_state_e;

  typedef logic [5:0]  pfp_code_t;
  typedef logic [1:0]  pfp_key_t;
  typedef logic [15:0] pfp_cnt_t;

endpackage

// >>> rtl/pfp_fuse_bank.sv
// fuse bank: image of the three fuse fields, sensed at start-up, set by blows
`timescale 1ns/1ps
`include "pfp_map.svh"

module pfp_fuse_bank
  import pfp_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // sensed fuse array
  input  wire logic [17:0]      fuse_sense,
  // blow completion
  input  wire logic             blow_done,
  input  wire pfp_pkg::pfp_key_t blow_key,
  input  wire pfp_pkg::pfp_code_t blow_mask,
  // fuse image
  output logic                  fuse_valid,
  output pfp_pkg::pfp_code_t    fuse_gain,
  output pfp_pkg::pfp_code_t    fuse_qlev,
  output pfp_pkg::pfp_code_t    fuse_k3
);

  typedef struct packed {
    logic      valid;
    pfp_code_t gain;
    pfp_code_t qlev;
    pfp_code_t k3;
  } pfp_bank_s;

  pfp_bank_s bank_r;
  pfp_bank_s bank_nxt;

  always_comb begin
    bank_nxt = bank_r;
    // the sense lines are caught on the first edge after reset release, never under reset
    if (!bank_r.valid) begin
      bank_nxt.valid = 1'b1;
      bank_nxt.gain  = fuse_sense[`PFP_FS_GAIN_MSB:`PFP_FS_GAIN_LSB];
      bank_nxt.qlev  = fuse_sense[`PFP_FS_QLEV_MSB:`PFP_FS_QLEV_LSB];
      bank_nxt.k3    = fuse_sense[`PFP_FS_K3_MSB:`PFP_FS_K3_LSB] & `PFP_K3_MAX;
    end else if (blow_done) begin
      case (blow_key)
        `PFP_KEY_GAIN: bank_nxt.gain = bank_r.gain | blow_mask;
        `PFP_KEY_QLEV: bank_nxt.qlev = bank_r.qlev | blow_mask;
        `PFP_KEY_K3:   bank_nxt.k3   = bank_r.k3 | (blow_mask & `PFP_K3_MAX);
        default:       bank_nxt = bank_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_r <= '0;
    end else begin
      bank_r <= bank_nxt;
    end
  end

  assign fuse_valid = bank_r.valid;
  assign fuse_gain  = bank_r.gain;
  assign fuse_qlev  = bank_r.qlev;
  assign fuse_k3    = bank_r.k3;

endmodule

// >>> rtl/pfp_fsm.sv
// programming state machine driven by high and mid level pulses on the sensor output pin
// Notes on behaviour
// - power-up: initial state, intact fuses read zero
// - initial state ignores mid pulses
// - high pulse in initial enters selection
// - mid pulses step key: gain, level, k3
// - high pulse in selection enters addressing once a key is chosen
// - addressing exits only by power or blow
// - trial code volatile; only blown bits permanent
// - high pulse in addressing blows the bits set in the trial code
// - gain code six bits, 0 to 63
// - quiescent level code six bits, 0 to 63
// - key three low bits: temp coefficient 0-7
// - key three bit three inverts slope
// - key three bit four locks everything
// - mid pulse fall increments trial, saturates
// - power cycle clears unblown bits only
// - locked device refuses all programming
`timescale 1ns/1ps
`include "pfp_map.svh"

module pfp_fsm
  import pfp_pkg::*;
#(
  parameter int unsigned BLOW_CYCLES = `PFP_BLOW_CYCLES
)
(
  // clock and power-on reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // qualified pulse indications from the level detector, one cycle each
  input  wire logic               high_program_pulse,
  input  wire logic               mid_program_pulse,
  // sensed fuse array: [5:0] gain, [11:6] level, [16:12] key three
  input  wire logic [17:0]        fuse_sense,
  // fuse blow drive
  output logic                    fuse_blow_en,
  output pfp_pkg::pfp_key_t       blow_key,
  output pfp_pkg::pfp_code_t      blow_mask,
  // effective parameter values
  output pfp_pkg::pfp_code_t      gain_code,
  output pfp_pkg::pfp_code_t      quiescent_level,
  output logic [2:0]              gain_temp_coeff,
  output logic                    slope_invert_flag,
  output logic                    lock_flag,
  // programming status
  output pfp_pkg::pfp_state_e     prog_state,
  output pfp_pkg::pfp_key_t       sel_key
);

  import pfp_pkg::*;

  typedef struct packed {
    pfp_state_e st;
    pfp_key_t   key;
    pfp_code_t  trial;
    pfp_cnt_t   blow_cnt;
    logic       blow_en;
    logic       blow_done;
    pfp_key_t   bkey;
    pfp_code_t  bmask;
    pfp_code_t  gain;
    pfp_code_t  qlev;
    logic [2:0] tc;
    logic       slope;
    logic       lock;
  } pfp_fsm_s;

  localparam pfp_cnt_t BLOW_LAST = pfp_cnt_t'(BLOW_CYCLES - 1);

  pfp_fsm_s  s_r;
  pfp_fsm_s  s_nxt;

  logic      fuse_valid;
  pfp_code_t fuse_gain;
  pfp_code_t fuse_qlev;
  pfp_code_t fuse_k3;

  // fuse image; blown bits survive any reset because they are resensed
  pfp_fuse_bank u_bank (
    .clk        (clk),
    .rst_b      (rst_b),
    .fuse_sense (fuse_sense),
    .blow_done  (s_r.blow_done),
    .blow_key   (s_r.bkey),
    .blow_mask  (s_r.bmask),
    .fuse_valid (fuse_valid),
    .fuse_gain  (fuse_gain),
    .fuse_qlev  (fuse_qlev),
    .fuse_k3    (fuse_k3)
  );

  // highest trial code of each register
  function automatic pfp_code_t key_max(input pfp_key_t k);
    pfp_code_t m;
    case (k)
      `PFP_KEY_GAIN: m = `PFP_GAIN_MAX;
      `PFP_KEY_QLEV: m = `PFP_QLEV_MAX;
      `PFP_KEY_K3:   m = `PFP_K3_MAX;
      default:       m = `PFP_CODE_ZERO;
    endcase
    return m;
  endfunction

  logic      locked;
  pfp_code_t tr_gain;
  pfp_code_t tr_qlev;
  pfp_code_t tr_k3;
  pfp_code_t eff_k3;

  // the trial only overlays the register being addressed; fuses always show through
  always_comb begin
    locked  = fuse_valid & fuse_k3[`PFP_LOCK_BIT];
    tr_gain = `PFP_CODE_ZERO;
    tr_qlev = `PFP_CODE_ZERO;
    tr_k3   = `PFP_CODE_ZERO;
    if (s_r.st == PFP_ST_ADDR || s_r.st == PFP_ST_BLOW || s_r.st == PFP_ST_DONE) begin
      case (s_r.key)
        `PFP_KEY_GAIN: tr_gain = s_r.trial;
        `PFP_KEY_QLEV: tr_qlev = s_r.trial;
        `PFP_KEY_K3:   tr_k3   = s_r.trial;
        default:       tr_gain = `PFP_CODE_ZERO;
      endcase
    end
    eff_k3 = fuse_k3 | tr_k3;
  end

  always_comb begin
    s_nxt           = s_r;
    s_nxt.blow_done = 1'b0;
    case (s_r.st)
      PFP_ST_INIT: begin
        // mid pulses fall through untouched here
        if (high_program_pulse && fuse_valid && !locked) begin
          s_nxt.st  = PFP_ST_SEL;
          s_nxt.key = `PFP_KEY_NONE;
        end
      end
      PFP_ST_SEL: begin
        if (high_program_pulse) begin
          // with no key yet there is no register to address, so the pulse is dropped
          if (s_r.key != `PFP_KEY_NONE) begin
            s_nxt.st    = PFP_ST_ADDR;
            s_nxt.trial = `PFP_CODE_ZERO;
          end
        end else if (mid_program_pulse && s_r.key != `PFP_KEY_K3) begin
          s_nxt.key = pfp_key_t'(s_r.key + 2'h1);
        end
      end
      PFP_ST_ADDR: begin
        // no pulse leads back out of addressing; only a blow or power loss ends it
        if (high_program_pulse) begin
          s_nxt.st       = PFP_ST_BLOW;
          s_nxt.blow_en  = 1'b1;
          s_nxt.blow_cnt = '0;
          s_nxt.bkey     = s_r.key;
          s_nxt.bmask    = s_r.trial;
        end else if (mid_program_pulse && s_r.trial != key_max(s_r.key)) begin
          // the detector flags the falling edge of the mid pulse
          s_nxt.trial = pfp_code_t'(s_r.trial + 6'h01);
        end
      end
      PFP_ST_BLOW: begin
        // drive the blow for the full minimum duration
        if (s_r.blow_cnt == BLOW_LAST) begin
          s_nxt.st        = PFP_ST_DONE;
          s_nxt.blow_en   = 1'b0;
          s_nxt.blow_done = 1'b1;
        end else begin
          s_nxt.blow_cnt = pfp_cnt_t'(s_r.blow_cnt + 16'h0001);
        end
      end
      PFP_ST_DONE: begin
        // parked until the supply is cycled, which is what the programmer must do next
        s_nxt.st = PFP_ST_DONE;
      end
      default: begin
        s_nxt.st      = PFP_ST_INIT;
        s_nxt.blow_en = 1'b0;
      end
    endcase

    // effective values: blown bits or the volatile trial of the addressed register; the lock comes from blown bits alone
    s_nxt.gain  = fuse_gain | tr_gain;
    s_nxt.qlev  = fuse_qlev | tr_qlev;
    s_nxt.tc    = eff_k3[`PFP_TC_MSB:`PFP_TC_LSB];
    s_nxt.slope = eff_k3[`PFP_SLOPE_BIT];
    s_nxt.lock  = fuse_k3[`PFP_LOCK_BIT];
  end

  // reset clears every trial and volatile bit; fuses are re-read by the bank
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r          <= '0;
      s_r.st       <= PFP_ST_INIT;
      s_r.key      <= `PFP_KEY_NONE;
      s_r.trial    <= `PFP_CODE_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fuse_blow_en      = s_r.blow_en;
  assign blow_key          = s_r.bkey;
  assign blow_mask         = s_r.bmask;
  assign gain_code         = s_r.gain;
  assign quiescent_level   = s_r.qlev;
  assign gain_temp_coeff   = s_r.tc;
  assign slope_invert_flag = s_r.slope;
  assign lock_flag         = s_r.lock;
  assign prog_state        = s_r.st;
  assign sel_key           = s_r.key;

endmodule

// >>> sim/pfp_prog_model.sv
// programmer model: qualified high and mid pulses
`timescale 1ns/1ps
module pfp_prog_model (
  // clock
  input  wire logic clk,
  // pulse indications
  output logic      high_program_pulse,
  output logic      mid_program_pulse
);
  initial begin
    high_program_pulse = 1'b0;
    mid_program_pulse = 1'b0;
  end
  // random idle gap: prompt or slow programmer
  task automatic send(input logic hi, input int n);
    repeat (n) begin
      @(posedge clk);
      high_program_pulse <= hi;
      mid_program_pulse <= !hi;
      @(posedge clk);
      high_program_pulse <= 1'b0;
      mid_program_pulse <= 1'b0;
      repeat ($urandom_range(2, 4)) @(posedge clk);
    end
  endtask
endmodule

// >>> sim/pfp_fsm_chk.sv
// assertions on the programming state machine ports
`timescale 1ns/1ps
module pfp_fsm_chk
  import pfp_pkg::*;
#(parameter int unsigned BLOW_CYCLES = 8)
(
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_b,
  // pulses and fuses
  input wire logic                high_program_pulse,
  input wire logic                mid_program_pulse,
  input wire logic [17:0]         fuse_sense,
  // outputs
  input wire logic                fuse_blow_en,
  input wire pfp_pkg::pfp_code_t  gain_code,
  input wire logic                lock_flag,
  input wire pfp_pkg::pfp_state_e prog_state,
  input wire pfp_pkg::pfp_key_t   sel_key
);
  logic [15:0] run_r;
  wire logic hi = high_program_pulse;
  wire logic mi = mid_program_pulse;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) run_r <= 16'h0000;
    else run_r <= fuse_blow_en ? run_r + 16'h0001 : 16'h0000;
  sequence s_blow_req; prog_state == PFP_ST_ADDR && hi; endsequence
  sequence s_blow_on; prog_state == PFP_ST_BLOW && fuse_blow_en; endsequence
  chk_init_mid_ignored: assert property (
    prog_state == PFP_ST_INIT && mi && !hi |=> prog_state == PFP_ST_INIT) else $error("mid moved init");
  chk_init_high_sel: assert property (
    prog_state == PFP_ST_INIT && hi && !fuse_sense[16] && $past(rst_b, 2)
    |=> prog_state == PFP_ST_SEL) else $error("high did not select");
  chk_key_step: assert property (
    prog_state == PFP_ST_SEL && mi && !hi && sel_key != 2'h3
    |=> sel_key == $past(sel_key) + 2'h1) else $error("key did not step");
  chk_sel_to_addr: assert property (
    prog_state == PFP_ST_SEL && hi && sel_key != 2'h0 |=> prog_state == PFP_ST_ADDR)
    else $error("no addressing");
  chk_addr_holds: assert property (
    prog_state == PFP_ST_ADDR && !hi |=> prog_state == PFP_ST_ADDR) else $error("left addressing");
  chk_blow_start: assert property (s_blow_req |=> s_blow_on) else $error("no blow");
  chk_blow_length: assert property (
    $fell(fuse_blow_en) |-> run_r == BLOW_CYCLES && prog_state == PFP_ST_DONE)
    else $error("blow length");
  chk_trial_step: assert property (
    prog_state == PFP_ST_ADDR && sel_key == 2'h1 && mi && !hi && !$past(mi) && !$past(mi, 2)
    && fuse_sense[5:0] == 6'h00 && gain_code != 6'h3f
    |-> ##2 gain_code == $past(gain_code, 2) + 6'h01) else $error("trial step");
  chk_lock_refuse: assert property (
    prog_state == PFP_ST_INIT && hi && lock_flag |=> prog_state == PFP_ST_INIT)
    else $error("locked but moved");
endmodule
bind pfp_fsm pfp_fsm_chk #(.BLOW_CYCLES(BLOW_CYCLES)) i_pfp_fsm_chk (.clk, .rst_b,
  .high_program_pulse, .mid_program_pulse, .fuse_sense, .fuse_blow_en, .gain_code,
  .lock_flag, .prog_state, .sel_key);

// >>> sim/pfp_fsm_tb.sv
// self-checking bench of the programming state machine
`timescale 1ns/1ps
module pfp_fsm_tb;
  import pfp_pkg::*;
  logic               clk, rst_b, high_program_pulse, mid_program_pulse;
  logic [17:0]        fuse_sense;
  logic               fuse_blow_en, slope_invert_flag, lock_flag;
  logic [2:0]         gain_temp_coeff;
  pfp_key_t           blow_key, sel_key;
  pfp_code_t          blow_mask, gain_code, quiescent_level;
  pfp_state_e         prog_state;
  int                 mismatches, cmp_count, k;

  pfp_fsm #(.BLOW_CYCLES(8)) i_pfp_fsm (.clk, .rst_b, .high_program_pulse,
    .mid_program_pulse, .fuse_sense, .fuse_blow_en, .blow_key, .blow_mask, .gain_code,
    .quiescent_level, .gain_temp_coeff, .slope_invert_flag, .lock_flag, .prog_state, .sel_key);
  pfp_prog_model i_pfp_prog_model (.clk, .high_program_pulse, .mid_program_pulse);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // #1 lets the edge's register updates land first
  task automatic check(input logic ok, input string msg);
    #1;
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  // power cycle: clears every unblown location
  task automatic pwr();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  function automatic pfp_code_t max_of(input int key);
    return (key == 3) ? 6'h1f : 6'h3f;
  endfunction

  // field of one key as the bench's own fuse array holds it
  function automatic pfp_code_t fuse_of(input int key);
    return 6'(fuse_sense >> (6 * (key - 1)));
  endfunction

  // blown bits show through the trial, so the expectation is trial or fuses
  task automatic try_code(input int key, input int n);
    pfp_code_t e;
    pfp_code_t f;
    f = fuse_of(key);
    e = ((n > max_of(key)) ? max_of(key) : 6'(n)) | f;
    i_pfp_prog_model.send(1'b1, 1);
    i_pfp_prog_model.send(1'b0, key);
    i_pfp_prog_model.send(1'b1, 1);
    i_pfp_prog_model.send(1'b0, n);
    check(prog_state === PFP_ST_ADDR && sel_key === 2'(key), "key or state");
    case (key)
      1: check(gain_code === e, "gain");
      2: check(quiescent_level === e, "level");
      default: check({slope_invert_flag, gain_temp_coeff} === e[3:0], "k3");
    endcase
    if (key == 3) check(lock_flag === f[4], "trial lock");
  endtask

  // one bit per sequence, power cycled after each blow
  task automatic blow(input int key, input int n);
    try_code(key, n);
    i_pfp_prog_model.send(1'b1, 1);
    check(fuse_blow_en === 1'b1 && blow_mask === 6'(n) && blow_key === 2'(key), "blow");
    repeat (40) if (prog_state !== PFP_ST_DONE) @(posedge clk);
    check(prog_state === PFP_ST_DONE, "blow end");
    fuse_sense <= fuse_sense | (18'(6'(n)) << (6 * (key - 1)));
    pwr();
  endtask

  initial begin
    rst_b = 1'b0;
    fuse_sense = 18'h00000;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'he9c2));
    pwr();
    check(prog_state === PFP_ST_INIT && gain_code === 6'h00, "reset");
    i_pfp_prog_model.send(1'b0, 2);
    check(prog_state === PFP_ST_INIT && sel_key === 2'h0, "mid in init");
    i_pfp_prog_model.send(1'b1, 1);
    check(prog_state === PFP_ST_SEL, "select");
    i_pfp_prog_model.send(1'b1, 1);
    check(prog_state === PFP_ST_SEL && sel_key === 2'h0, "key zero");
    i_pfp_prog_model.send(1'b0, 4);
    check(prog_state === PFP_ST_SEL && sel_key === 2'h3, "key top");
    for (k = 1; k <= 3; k++) begin
      pwr();
      try_code(k, 70);
    end
    repeat (6) begin
      pwr();
      try_code($urandom_range(1, 3), $urandom_range(0, 40));
    end
    pwr();
    check(gain_code === 6'h00 && quiescent_level === 6'h00, "trial kept");
    blow(1, 4);
    check(gain_code === 6'h04, "fuse lost");
    blow(1, 1);
    check(gain_code === 6'h05, "second bit");
    blow(3, 16);
    check(lock_flag === 1'b1, "lock");
    i_pfp_prog_model.send(1'b1, 1);
    check(prog_state === PFP_ST_INIT, "locked");
    end_of_test();
  end

  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
endmodule
